// ===== inc/ccr_pkg.sv
// Purpose: Constants, field layouts and carrier types of the control register bank
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes: Offsets are byte addresses of a local map
package ccr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MAIN_MODE = 8'h00;
  localparam logic [7:0] OFS_UNDEF_SLOT = 8'h04;
  localparam logic [7:0] OFS_FAULT_ADDR = 8'h08;
  localparam logic [7:0] OFS_DIR_BASE = 8'h0C;
  localparam logic [7:0] OFS_FEATURE = 8'h10;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h14;
  localparam logic [7:0] OFS_CORE_STATUS = 8'h18;
  localparam logic [7:0] OFS_BP_CTRL = 8'h1C;

  // Main mode fields
  localparam int MM_PG_BIT = 31;
  localparam int MM_PE_BIT = 0;
  localparam int MM_FIXED1_BIT = 4;
  localparam logic [31:0] MM_WRITABLE = 32'hE005_002F;
  localparam logic [31:0] MM_RESET = 32'h0000_0010;

  // Directory base fields
  localparam int DB_BASE_LSB = 12;
  localparam int DB_PCD_BIT = 4;
  localparam int DB_PWT_BIT = 3;
  localparam logic [31:0] DB_WRITABLE = 32'hFFFF_F018;
  localparam logic [31:0] DB_RESET = 32'h0000_0000;

  // Feature fields
  localparam int FT_TSD_BIT = 2;
  localparam int FT_DE_BIT = 3;
  localparam int FT_PGE_BIT = 7;
  localparam int FT_PCE_BIT = 8;
  localparam logic [31:0] FT_WRITABLE = 32'h0000_018C;
  localparam logic [31:0] FT_RESET = 32'h0000_0000;

  localparam logic [31:0] FA_RESET = 32'h0000_0000;
  localparam logic [7:0] BP_RESET = 8'h00;
  localparam logic [31:0] UNDEF_READ = 32'h0000_0000;
  localparam logic [1:0] PL_KERNEL = 2'h0;
  localparam int BP_COUNT = 4;

  // Breakpoint type field codes
  localparam logic [1:0] BPT_EXEC = 2'h0;
  localparam logic [1:0] BPT_WRITE = 2'h1;
  localparam logic [1:0] BPT_IO = 2'h2;
  localparam logic [1:0] BPT_RDWR = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded breakpoint match kinds per breakpoint; the read/write code sets both data_wr and data_rd
  typedef struct packed {
    logic exec;
    logic data_wr;
    logic data_rd;
    logic io;
  } ccr_bp_kind_t;

  // Core-side event and privilege inputs
  typedef struct packed {
    logic fault_valid;
    logic [31:0] fault_addr;
    logic [1:0] priv_level;
    logic bus_cycle_paged;
    logic inta_cycle;
  } ccr_core_in_t;

endpackage : ccr_pkg

// ===== core/ccr_bp_decode.sv
// Purpose: Decode of one breakpoint type field into access kinds
// Assumes: I/O kind exists only with debugging extensions on
// Notes: Without extensions the I/O code falls back to no match
`timescale 1ns/1ps
module ccr_bp_decode (
  // Control
  input wire logic ext_en,
  input wire logic [1:0] type_code,
  // Result
  output ccr_pkg::ccr_bp_kind_t kind
);

  always_comb begin
    kind = '0;
    case (type_code)
      ccr_pkg::BPT_EXEC: kind.exec = 1'b1;
      ccr_pkg::BPT_WRITE: kind.data_wr = 1'b1;
      ccr_pkg::BPT_IO: kind.io = ext_en;
      ccr_pkg::BPT_RDWR: begin
        kind.data_wr = 1'b1;
        kind.data_rd = 1'b1;
      end
      default: kind = '0;
    endcase
  end

endmodule : ccr_bp_decode

// ===== core/ccr_bank.sv
// Purpose: Control register bank with AXI4-Lite access and core-side decode
// Assumes: Core events are synchronous to ref_clk; one clock domain
// Notes: Privileged software reaches the bank over the bus
`timescale 1ns/1ps
module ccr_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  input ccr_pkg::ccr_core_in_t core_in,
  input wire logic flush_req,
  // Core decode outputs
  output logic paging_active,
  output logic [31:0] directory_base_addr,
  output logic page_cache_disable,
  output logic page_write_through,
  output logic timestamp_read_allowed,
  output logic perf_counter_read_allowed,
  output logic flush_keep_global,
  output ccr_pkg::ccr_bp_kind_t [ccr_pkg::BP_COUNT-1:0] bp_kind
);

  logic [31:0] main_mode_r, main_mode_nxt;
  logic [31:0] fault_addr_r, fault_addr_nxt;
  logic [31:0] dir_base_r, dir_base_nxt;
  logic [31:0] feature_r, feature_nxt;
  logic [7:0] bp_ctrl_r, bp_ctrl_nxt;
  logic pcd_r, pcd_nxt;
  logic pwt_r, pwt_nxt;

  logic aw_held_r, aw_held_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic w_held_r, w_held_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic wr_fire;
  logic rd_fire;
  logic [31:0] wmask;

  // Byte strobes to bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : strb_mask

  // Write merges only writable bits under strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [31:0] mask);
    return (old & ~mask) | (data & mask);
  endfunction : merge

  // Bus handshake
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Response waits for both halves; a pending bvalid blocks new write requests
  assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  assign rd_fire = s_axi_arvalid & ~rvalid_r;
  assign wmask = strb_mask(w_strb_r);

  // Address and data may be taken in either order
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      case ({aw_addr_r[7:2], 2'b00})
        ccr_pkg::OFS_MAIN_MODE, ccr_pkg::OFS_UNDEF_SLOT, ccr_pkg::OFS_FAULT_ADDR,
        ccr_pkg::OFS_DIR_BASE, ccr_pkg::OFS_FEATURE, ccr_pkg::OFS_STATUS_WORD,
        ccr_pkg::OFS_CORE_STATUS, ccr_pkg::OFS_BP_CTRL: bresp_nxt = ccr_pkg::RESP_OKAY;
        default: bresp_nxt = ccr_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // Register contents
  always_comb begin
    main_mode_nxt = main_mode_r;
    fault_addr_nxt = fault_addr_r;
    dir_base_nxt = dir_base_r;
    feature_nxt = feature_r;
    bp_ctrl_nxt = bp_ctrl_r;
    if (wr_fire) begin
      case ({aw_addr_r[7:2], 2'b00})
        // Reserved bits stay put; software should write them back unchanged
        ccr_pkg::OFS_MAIN_MODE:
          main_mode_nxt = merge(main_mode_r, w_data_r, wmask & ccr_pkg::MM_WRITABLE);
        ccr_pkg::OFS_STATUS_WORD:
          main_mode_nxt = merge(main_mode_r, w_data_r,
                                wmask & ccr_pkg::MM_WRITABLE & 32'h0000_FFFF);
        ccr_pkg::OFS_FAULT_ADDR: fault_addr_nxt = merge(fault_addr_r, w_data_r, wmask);
        ccr_pkg::OFS_DIR_BASE:
          dir_base_nxt = merge(dir_base_r, w_data_r, wmask & ccr_pkg::DB_WRITABLE);
        ccr_pkg::OFS_FEATURE:
          feature_nxt = merge(feature_r, w_data_r, wmask & ccr_pkg::FT_WRITABLE);
        ccr_pkg::OFS_BP_CTRL: if (w_strb_r[0]) bp_ctrl_nxt = w_data_r[7:0];
        default: begin
        end
      endcase
    end
    // Fault wins over a same-cycle software write; a later fault overwrites
    if (core_in.fault_valid && paging_active) begin
      fault_addr_nxt = core_in.fault_addr;
    end
    main_mode_nxt[ccr_pkg::MM_FIXED1_BIT] = 1'b1;
  end

  // Read path
  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = ccr_pkg::RESP_OKAY;
      // Undefined slot answers OKAY with zero; unmapped words answer SLVERR
      case ({s_axi_araddr[7:2], 2'b00})
        ccr_pkg::OFS_MAIN_MODE: rdata_nxt = main_mode_r;
        ccr_pkg::OFS_UNDEF_SLOT: rdata_nxt = ccr_pkg::UNDEF_READ;
        ccr_pkg::OFS_FAULT_ADDR: rdata_nxt = fault_addr_r;
        ccr_pkg::OFS_DIR_BASE: rdata_nxt = dir_base_r;
        ccr_pkg::OFS_FEATURE: rdata_nxt = feature_r;
        ccr_pkg::OFS_STATUS_WORD: rdata_nxt = {16'h0000, main_mode_r[15:0]};
        ccr_pkg::OFS_CORE_STATUS:
          rdata_nxt = {29'h0000_0000, pcd_r, pwt_r, paging_active};
        ccr_pkg::OFS_BP_CTRL: rdata_nxt = {24'h00_0000, bp_ctrl_r};
        default: begin
          rdata_nxt = '0;
          rresp_nxt = ccr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Cache attribute pins; paged cycles take attributes from elsewhere
  always_comb begin
    pcd_nxt = 1'b0;
    pwt_nxt = 1'b0;
    if (!paging_active || core_in.inta_cycle || !core_in.bus_cycle_paged) begin
      pcd_nxt = dir_base_r[ccr_pkg::DB_PCD_BIT];
      pwt_nxt = dir_base_r[ccr_pkg::DB_PWT_BIT];
    end
  end

  // Write channel state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= ccr_pkg::RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // Architectural registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_mode_r <= ccr_pkg::MM_RESET;
      fault_addr_r <= ccr_pkg::FA_RESET;
      dir_base_r <= ccr_pkg::DB_RESET;
      feature_r <= ccr_pkg::FT_RESET;
      bp_ctrl_r <= ccr_pkg::BP_RESET;
    end else begin
      main_mode_r <= main_mode_nxt;
      fault_addr_r <= fault_addr_nxt;
      dir_base_r <= dir_base_nxt;
      feature_r <= feature_nxt;
      bp_ctrl_r <= bp_ctrl_nxt;
    end
  end

  // Read channel state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
      rresp_r <= ccr_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Cache attribute pins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pcd_r <= 1'b0;
      pwt_r <= 1'b0;
    end else begin
      pcd_r <= pcd_nxt;
      pwt_r <= pwt_nxt;
    end
  end

  // Core-facing decode
  assign paging_active = main_mode_r[ccr_pkg::MM_PG_BIT] &
                         main_mode_r[ccr_pkg::MM_PE_BIT];
  assign directory_base_addr = {dir_base_r[31:ccr_pkg::DB_BASE_LSB], 12'h000};
  assign page_cache_disable = pcd_r;
  assign page_write_through = pwt_r;
  assign timestamp_read_allowed = ~feature_r[ccr_pkg::FT_TSD_BIT] |
                                  (core_in.priv_level == ccr_pkg::PL_KERNEL);
  assign perf_counter_read_allowed = feature_r[ccr_pkg::FT_PCE_BIT] |
                                     (core_in.priv_level == ccr_pkg::PL_KERNEL);
  // Flush spares global entries only when the feature is on
  assign flush_keep_global = flush_req & feature_r[ccr_pkg::FT_PGE_BIT];

  // One decoder per breakpoint type field
  genvar g;
  generate
    for (g = 0; g < ccr_pkg::BP_COUNT; g++) begin : g_bp
      ccr_bp_decode u_dec (
        .ext_en(feature_r[ccr_pkg::FT_DE_BIT]),
        .type_code(bp_ctrl_r[g*2 +: 2]),
        .kind(bp_kind[g])
      );
    end
  endgenerate

endmodule : ccr_bank

// ===== test/ccr_bank_chk.sv
// Purpose: Port assertions for the control register bank
// Assumes: One clock, async active-low reset
// Notes: Sees only the bank's ports
`timescale 1ns/1ps
module ccr_bank_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Core side
  input ccr_pkg::ccr_core_in_t core_in,
  input wire logic flush_req,
  input wire logic paging_active,
  input wire logic [31:0] directory_base_addr,
  input wire logic page_cache_disable,
  input wire logic page_write_through,
  input wire logic timestamp_read_allowed,
  input wire logic perf_counter_read_allowed,
  input wire logic flush_keep_global
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_dir_align; directory_base_addr[11:0] == 12'h000; endproperty
  a_dir_align: assert property (p_dir_align) else $error("base low bits set");
  property p_ts_kernel; core_in.priv_level == 2'h0 |-> timestamp_read_allowed; endproperty
  a_ts_kernel: assert property (p_ts_kernel) else $error("timestamp refused");
  property p_pc_kernel; core_in.priv_level == 2'h0 |-> perf_counter_read_allowed; endproperty
  a_pc_kernel: assert property (p_pc_kernel) else $error("counter refused");
  property p_keep; flush_keep_global |-> flush_req; endproperty
  a_keep: assert property (p_keep) else $error("keep without flush");
  property p_paged_pins;
    core_in.bus_cycle_paged && !core_in.inta_cycle && paging_active
      |=> !page_cache_disable && !page_write_through;
  endproperty
  a_paged_pins: assert property (p_paged_pins) else $error("pins on paged cycle");
  property p_pg_change; $changed(paging_active) |-> $rose(s_axi_bvalid); endproperty
  a_pg_change: assert property (p_pg_change) else $error("paging moved alone");
  property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("no read answer");
  property p_rd_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rd_drop: assert property (p_rd_drop) else $error("read answer stuck");
  property p_wr_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_wr_drop: assert property (p_wr_drop) else $error("write answer stuck");
  c_fault: cover property (core_in.fault_valid && paging_active);
  c_keep: cover property (flush_keep_global);
  c_inta: cover property (core_in.inta_cycle && paging_active);
endmodule : ccr_bank_chk
bind ccr_bank ccr_bank_chk ccr_bank_chk_inst (.ref_clk, .reset_n, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .core_in,
  .flush_req, .paging_active, .directory_base_addr, .page_cache_disable, .page_write_through,
  .timestamp_read_allowed, .perf_counter_read_allowed, .flush_keep_global);

// ===== test/ccr_core_model.sv
// Purpose: Core-side event source facing the bank
// Assumes: Tasks are entered just after a rising edge
// Notes: Address lines change outside a fault pulse
`timescale 1ns/1ps
module ccr_core_model (
  // Clock
  input wire logic ref_clk,
  // Core events
  output ccr_pkg::ccr_core_in_t core_in,
  output logic flush_req
);
  initial begin
    core_in = '0;
    flush_req = 1'b0;
  end
  task automatic set(input logic paged, input logic inta, input logic [1:0] lvl, input logic fl);
    core_in.bus_cycle_paged <= paged;
    core_in.inta_cycle <= inta;
    core_in.priv_level <= lvl;
    flush_req <= fl;
  endtask : set
  task automatic fault(input logic [31:0] a);
    core_in.fault_valid <= 1'b1;
    core_in.fault_addr <= a;
    @(posedge ref_clk);
    core_in.fault_valid <= 1'b0;
    // Stale address must not be mistaken for a capture
    core_in.fault_addr <= ~a;
  endtask : fault
endmodule : ccr_core_model

// ===== test/tb.sv
// Purpose: Self-checking bench of the control register bank
// Assumes: Responses stay ready; full byte strobes
// Notes: Read results are scored from a queue
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, directory_base_addr, a1, a2;
  ccr_pkg::ccr_core_in_t core_in;
  logic flush_req, paging_active, page_cache_disable, page_write_through;
  logic timestamp_read_allowed, perf_counter_read_allowed, flush_keep_global;
  ccr_pkg::ccr_bp_kind_t [ccr_pkg::BP_COUNT-1:0] bp_kind;
  logic [33:0] exp_q[$];
  int fails = 0, comparisons = 0, seed = 83;
  ccr_bank ccr_bank_inst (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .core_in, .flush_req, .paging_active, .directory_base_addr,
    .page_cache_disable, .page_write_through, .timestamp_read_allowed,
    .perf_counter_read_allowed, .flush_keep_global, .bp_kind);
  ccr_core_model ccr_core_model_inst (.ref_clk, .core_in, .flush_req);
  always #25 ref_clk = ~ref_clk;
  task automatic check(input string n, input logic [33:0] s, input logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    check("bresp", s_axi_bresp, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
  endtask : rd
  task automatic pins(input logic paged, input logic inta, input logic [1:0] lvl,
                      input logic fl, input logic [1:0] e);
    ccr_core_model_inst.set(paged, inta, lvl, fl);
    // Pins register the inputs one edge late; sample at the edge after
    repeat (2) @(posedge ref_clk);
    check("pins", {page_cache_disable, page_write_through}, e);
  endtask : pins
  always @(posedge ref_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      check("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #(50 * 4000);
    fails++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(ccr_pkg::OFS_MAIN_MODE, {2'h0, 32'h0000_0010});
    wr(ccr_pkg::OFS_UNDEF_SLOT, 32'hFFFF_FFFF, ccr_pkg::RESP_OKAY);
    rd(ccr_pkg::OFS_UNDEF_SLOT, 34'h0);
    wr(8'h20, 32'hFFFF_FFFF, ccr_pkg::RESP_SLVERR);
    rd(8'h20, {ccr_pkg::RESP_SLVERR, 32'h0000_0000});
    wr(ccr_pkg::OFS_DIR_BASE, 32'hFFFF_FFFF, ccr_pkg::RESP_OKAY);
    rd(ccr_pkg::OFS_DIR_BASE, {2'h0, 32'hFFFF_F018});
    check("base", directory_base_addr, 32'hFFFF_F000);
    pins(1'b1, 1'b0, 2'h3, 1'b0, 2'b11);
    wr(ccr_pkg::OFS_DIR_BASE, 32'h0000_0008, ccr_pkg::RESP_OKAY);
    pins(1'b1, 1'b0, 2'h0, 1'b0, 2'b01);
    ccr_core_model_inst.fault(32'hDEAD_0000);
    rd(ccr_pkg::OFS_FAULT_ADDR, 34'h0);
    // Reserved bits kept at their reset state
    wr(ccr_pkg::OFS_MAIN_MODE, 32'h8000_0011, ccr_pkg::RESP_OKAY);
    check("paging", paging_active, 1'b1);
    rd(ccr_pkg::OFS_STATUS_WORD, {2'h0, 32'h0000_0011});
    pins(1'b1, 1'b0, 2'h0, 1'b0, 2'b00);
    pins(1'b1, 1'b1, 2'h0, 1'b0, 2'b01);
    a1 = $random(seed);
    a2 = $random(seed);
    ccr_core_model_inst.fault(a1);
    @(posedge ref_clk);
    ccr_core_model_inst.fault(a2);
    rd(ccr_pkg::OFS_FAULT_ADDR, {2'h0, a2});
    repeat (20) @(posedge ref_clk);
    rd(ccr_pkg::OFS_FAULT_ADDR, {2'h0, a2});
    wr(ccr_pkg::OFS_FAULT_ADDR, a1, ccr_pkg::RESP_OKAY);
    rd(ccr_pkg::OFS_FAULT_ADDR, {2'h0, a1});
    wr(ccr_pkg::OFS_BP_CTRL, 32'h0000_00E4, ccr_pkg::RESP_OKAY);
    for (int f = 0; f < 2; f++) begin
      wr(ccr_pkg::OFS_FEATURE, f ? 32'h0000_018C : 32'h0, ccr_pkg::RESP_OKAY);
      for (int l = 0; l < 4; l++) begin
        pins(1'b0, 1'b0, l[1:0], 1'b1, 2'b01);
        check("ts", timestamp_read_allowed, f == 0 || l == 0);
        check("pc", perf_counter_read_allowed, f == 1 || l == 0);
        check("keep", flush_keep_global, f == 1);
      end
      check("bp", bp_kind, {4'b0110, f ? 4'b0001 : 4'b0000, 4'b0100, 4'b1000});
    end
    // Status word write keeps the upper half; reserved bits written back as read
    wr(ccr_pkg::OFS_STATUS_WORD, 32'h0000_003E, ccr_pkg::RESP_OKAY);
    rd(ccr_pkg::OFS_MAIN_MODE, {2'h0, 32'h8000_003E});
    check("paging", paging_active, 1'b0);
    rd(ccr_pkg::OFS_CORE_STATUS, {2'h0, 32'h0000_0002});
    ccr_core_model_inst.set(1'b0, 1'b0, 2'h0, 1'b0);
    repeat (2) @(posedge ref_clk);
    give_verdict();
  end
endmodule : tb
